// File: src/updown_timer.sv
// up/down timer with capture and pwm, avalon-mm register slave
//
// The register addresses and the Avalon-MM register port were decided locally.
module updown_timer #(
  parameter int EVT_N = 16
) (
  input  wire logic                     clk,
  input  wire logic                     rstn,
  input  wire logic                     ce,
  input  wire logic [5:0]               address,
  input  wire logic                     read,
  input  wire logic                     write,
  input  wire logic [31:0]              writedata,
  input  wire logic [3:0]               byteenable,
  output logic      [31:0]              readdata,
  output logic                          waitrequest,
  input  wire logic                     fast_rc_oscillator,
  input  wire logic                     slow_rc_oscillator,
  input  wire logic                     slow_crystal_oscillator,
  input  wire logic [EVT_N-1:0]         event_bus,
  output logic                          timer_output,
  output logic                          irq
);

  ////////////////////////////////////////////////////////////////////////
  // bus slave

  updown_timer_pkg::timer_control_t con_q;
  updown_timer_pkg::pwm_control_t   pcon_q, pcon_e_q;
  logic [15:0] ld_q, ld_t_q, pmat_q, pmat_e_q;
  logic [15:0] cnt_q, cnt_next, sync_q, cap_q, start_val;
  logic        ack_q, acc_wr, acc_rd;
  logic        to_q, capf_q, busy_q, en_t_q, ld_pend_q, evt_q;
  logic [1:0]  bsy_cnt_q;
  logic [14:0] psc_q, ratio_m1;
  logic        src_tick, ptick, tick, term, en_apply, en_chg;
  logic        clr_wr, clr_to, clr_cap, set_to, cap_ev, match_hit;
  logic [15:0] wd16, con_wr;

  function automatic logic [15:0] merge16(input logic [15:0] old,
                                           input logic [15:0] wd,
                                           input logic [1:0]  be);
    merge16 = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
  endfunction : merge16

  // one wait state on every access
  assign waitrequest = (read | write) & ~ack_q;
  assign acc_wr      = ce & write & ack_q;
  assign acc_rd      = ce & read & ack_q;
  assign wd16        = writedata[15:0];

  always_ff @(posedge clk) begin
    if (!rstn) begin
      ack_q <= 1'b0;
    end else if (ce) begin
      ack_q <= (read | write) & ~ack_q;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      readdata <= updown_timer_pkg::ZERO32;
    end else if (ce && read && !ack_q) begin
      readdata <= updown_timer_pkg::ZERO32;
      if (address == updown_timer_pkg::LD_OFF) begin
        readdata[15:0] <= ld_q;
      end else if (address == updown_timer_pkg::VAL_OFF) begin
        readdata[15:0] <= sync_q;
      end else if (address == updown_timer_pkg::CON_OFF) begin
        readdata[15:0] <= {4'h0, con_q};
      end else if (address == updown_timer_pkg::CAP_OFF) begin
        readdata[15:0] <= cap_q;
      end else if (address == updown_timer_pkg::ALD_OFF) begin
        readdata[15:0] <= ld_t_q;
      end else if (address == updown_timer_pkg::AVAL_OFF) begin
        readdata[15:0] <= cnt_q;
      end else if (address == updown_timer_pkg::STA_OFF) begin
        readdata[updown_timer_pkg::STA_TO_BIT]   <= to_q;
        readdata[updown_timer_pkg::STA_CAP_BIT]  <= capf_q;
        readdata[updown_timer_pkg::STA_BUSY_BIT] <= busy_q;
      end else if (address == updown_timer_pkg::PCON_OFF) begin
        readdata[1:0] <= pcon_q;
      end else if (address == updown_timer_pkg::PMAT_OFF) begin
        readdata[15:0] <= pmat_q;
      end
    end
  end

  assign con_wr = merge16({4'h0, con_q}, wd16, byteenable[1:0]);
  assign en_chg = acc_wr && address == updown_timer_pkg::CON_OFF
                  && con_wr[4] != con_q.enable;
  assign clr_wr  = acc_wr && address == updown_timer_pkg::CLRI_OFF && byteenable[0];
  assign clr_to  = clr_wr && writedata[updown_timer_pkg::STA_TO_BIT];
  assign clr_cap = clr_wr && writedata[updown_timer_pkg::STA_CAP_BIT];

  always_ff @(posedge clk) begin
    if (!rstn) begin
      con_q  <= updown_timer_pkg::timer_control_t'(updown_timer_pkg::CON_RST[11:0]);
      pcon_q <= '0;
      pmat_q <= updown_timer_pkg::ZERO16;
      ld_q   <= updown_timer_pkg::ZERO16;
    end else if (acc_wr) begin
      if (address == updown_timer_pkg::CON_OFF) begin
        con_q <= updown_timer_pkg::timer_control_t'(con_wr[11:0]);
      end else if (address == updown_timer_pkg::PCON_OFF) begin
        if (byteenable[0]) begin
          pcon_q <= writedata[1:0];
        end
      end else if (address == updown_timer_pkg::PMAT_OFF) begin
        pmat_q <= merge16(pmat_q, wd16, byteenable[1:0]);
      end else if (address == updown_timer_pkg::LD_OFF) begin
        ld_q <= merge16(ld_q, wd16, byteenable[1:0]);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // clock source, enable crossing, load transfer

  always_comb begin
    src_tick = 1'b1;
    case (con_q.clk_sel)
      2'h1:    src_tick = fast_rc_oscillator;
      2'h2:    src_tick = slow_rc_oscillator;
      2'h3:    src_tick = slow_crystal_oscillator;
      default: src_tick = 1'b1;
    endcase
  end

  // software must keep clear of registers while busy; nothing blocks it
  always_ff @(posedge clk) begin
    if (!rstn) begin
      busy_q    <= 1'b0;
      bsy_cnt_q <= 2'h0;
      en_t_q    <= 1'b0;
    end else if (ce) begin
      if (en_chg) begin
        busy_q    <= 1'b1;
        bsy_cnt_q <= 2'h0;
      end else if (busy_q && src_tick) begin
        if (bsy_cnt_q == updown_timer_pkg::SYNC_TICKS - 2'h1) begin
          busy_q <= 1'b0;
          en_t_q <= con_q.enable;
        end
        bsy_cnt_q <= bsy_cnt_q + 2'h1;
      end
    end
  end

  assign en_apply = ce && busy_q && src_tick &&
                    bsy_cnt_q == updown_timer_pkg::SYNC_TICKS - 2'h1;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      ld_t_q    <= updown_timer_pkg::ZERO16;
      ld_pend_q <= 1'b0;
    end else if (ce) begin
      if (acc_wr && address == updown_timer_pkg::ALD_OFF) begin
        ld_t_q    <= merge16(ld_t_q, wd16, byteenable[1:0]);
        ld_pend_q <= 1'b0;
      end else if (acc_wr && address == updown_timer_pkg::LD_OFF) begin
        ld_pend_q <= 1'b1;
      end else if (ld_pend_q && src_tick) begin
        ld_t_q    <= ld_q;
        ld_pend_q <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // prescaler

  always_comb begin
    ratio_m1 = updown_timer_pkg::DIV32K_M1;
    case (con_q.prescale)
      updown_timer_pkg::PSC_LOW: begin
        // fast sources cannot run undivided: core must be 4x faster
        if (con_q.clk_sel == updown_timer_pkg::SRC_PCLK ||
            con_q.clk_sel == updown_timer_pkg::SRC_FAST) begin
          ratio_m1 = updown_timer_pkg::DIV4_M1;
        end else begin
          ratio_m1 = updown_timer_pkg::DIV1_M1;
        end
      end
      updown_timer_pkg::PSC_16:  ratio_m1 = updown_timer_pkg::DIV16_M1;
      updown_timer_pkg::PSC_256: ratio_m1 = updown_timer_pkg::DIV256_M1;
      default:                   ratio_m1 = updown_timer_pkg::DIV32K_M1;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      psc_q <= '0;
    end else if (ce) begin
      if (!en_t_q) begin
        psc_q <= '0;
      end else if (src_tick) begin
        psc_q <= (psc_q >= ratio_m1) ? '0 : psc_q + 15'h0001;
      end
    end
  end

  assign ptick = src_tick && en_t_q && psc_q >= ratio_m1;
  assign tick  = ce && ptick;

  ////////////////////////////////////////////////////////////////////////
  // counter

  assign term = con_q.count_up ? (cnt_q == updown_timer_pkg::FULL16)
                               : (cnt_q == updown_timer_pkg::ZERO16);

  always_comb begin
    if (con_q.periodic_select) begin
      start_val = ld_t_q;
    end else if (con_q.count_up) begin
      start_val = updown_timer_pkg::ZERO16;
    end else begin
      start_val = updown_timer_pkg::FULL16;
    end
  end

  always_comb begin
    if (term) begin
      cnt_next = start_val;
    end else if (con_q.count_up) begin
      cnt_next = cnt_q + 16'h0001;
    end else begin
      cnt_next = cnt_q - 16'h0001;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      cnt_q <= updown_timer_pkg::ZERO16;
    end else if (ce) begin
      if (en_apply && con_q.enable) begin
        cnt_q <= start_val;
      end else if (clr_to && con_q.reload_on_clr) begin
        cnt_q <= start_val;
      end else if (ptick) begin
        cnt_q <= cnt_next;
      end
    end
  end

  // one core clock behind the live count, always coherent
  always_ff @(posedge clk) begin
    if (!rstn) begin
      sync_q <= updown_timer_pkg::ZERO16;
    end else if (ce) begin
      sync_q <= cnt_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // status flags, capture, interrupt

  assign set_to = tick && term;
  assign cap_ev = ce && event_bus[con_q.evt_sel] && !evt_q &&
                  (!capf_q || clr_cap);

  always_ff @(posedge clk) begin
    if (!rstn) begin
      to_q   <= 1'b0;
      capf_q <= 1'b0;
      evt_q  <= 1'b0;
      cap_q  <= updown_timer_pkg::ZERO16;
    end else if (ce) begin
      evt_q <= event_bus[con_q.evt_sel];
      if (set_to) begin
        to_q <= 1'b1;
      end else if (clr_to) begin
        to_q <= 1'b0;
      end
      if (cap_ev) begin
        capf_q <= 1'b1;
        cap_q  <= cnt_q;
      end else if (clr_cap) begin
        capf_q <= 1'b0;
      end
    end
  end

  assign irq = to_q | capf_q;

  ////////////////////////////////////////////////////////////////////////
  // pwm

  assign match_hit = pcon_e_q.match_en && cnt_next == pmat_e_q;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      pcon_e_q     <= '0;
      pmat_e_q     <= updown_timer_pkg::ZERO16;
      timer_output <= 1'b0;
    end else if (ce) begin
      if (clr_wr || en_apply) begin
        pcon_e_q     <= pcon_q;
        pmat_e_q     <= pmat_q;
        timer_output <= pcon_q.idle_level;
      end else if (ptick) begin
        if (match_hit) begin
          timer_output <= ~pcon_e_q.idle_level;
        end else if (term && pcon_e_q.match_en) begin
          timer_output <= pcon_e_q.idle_level;
        end else if (term) begin
          timer_output <= ~timer_output;
        end
        if (match_hit || term) begin
          pcon_e_q <= pcon_q;
          pmat_e_q <= pmat_q;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // assertions

  timeout_flag_a: assert property (@(posedge clk) disable iff (!rstn)
    set_to |=> to_q && irq)
    else $error("timeout did not set status");

  free_wrap_a: assert property (@(posedge clk) disable iff (!rstn)
    set_to && !con_q.periodic_select && !en_apply |=>
      cnt_q == ($past(con_q.count_up) ? 16'h0000 : 16'hFFFF))
    else $error("free run did not wrap to opposite extreme");

  periodic_load_a: assert property (@(posedge clk) disable iff (!rstn)
    set_to && con_q.periodic_select && !en_apply |=> cnt_q == $past(ld_t_q))
    else $error("periodic mode did not reload");

  count_step_a: assert property (@(posedge clk) disable iff (!rstn)
    tick && !term && !clr_to && !en_apply |=>
      cnt_q == ($past(con_q.count_up) ? $past(cnt_q) + 16'h0001
                                      : $past(cnt_q) - 16'h0001))
    else $error("count step wrong");

  clear_reload_a: assert property (@(posedge clk) disable iff (!rstn)
    clr_to && con_q.reload_on_clr && !en_apply |=> cnt_q == $past(start_val))
    else $error("clear did not reload counter");

  capture_copy_a: assert property (@(posedge clk) disable iff (!rstn)
    cap_ev |=> cap_q == $past(cnt_q) && capf_q)
    else $error("capture value wrong");

  capture_lock_a: assert property (@(posedge clk) disable iff (!rstn)
    capf_q && !clr_cap |=> $stable(cap_q) && capf_q)
    else $error("locked capture overwritten");

  busy_cross_a: assert property (@(posedge clk) disable iff (!rstn)
    en_chg |=> busy_q && $stable(en_t_q))
    else $error("busy not raised on enable change");

  min_ratio_a: assert property (@(posedge clk) disable iff (!rstn)
    con_q.clk_sel[1] == 1'b0 |-> ratio_m1 >= 15'h0003)
    else $error("fast source undivided");

  toggle_out_a: assert property (@(posedge clk) disable iff (!rstn)
    set_to && !pcon_e_q.match_en && !clr_wr && !en_apply |=>
      timer_output != $past(timer_output))
    else $error("toggle mode did not invert");

  match_wins_a: assert property (@(posedge clk) disable iff (!rstn)
    tick && match_hit && !clr_wr && !en_apply |=>
      timer_output == ~$past(pcon_e_q.idle_level))
    else $error("match lost to timeout");

  synced_lag_a: assert property (@(posedge clk) disable iff (!rstn)
    ce |=> sync_q == $past(cnt_q))
    else $error("synced count not one cycle behind");

  cover_timeout_c: cover property (@(posedge clk) disable iff (!rstn) set_to);
  cover_capture_c: cover property (@(posedge clk) disable iff (!rstn) cap_ev);
  cover_match_c: cover property (@(posedge clk) disable iff (!rstn)
    tick && match_hit && term);
  cover_enable_c: cover property (@(posedge clk) disable iff (!rstn) en_apply);

endmodule : updown_timer

// File: src/updown_timer_pkg.sv
// constants, register map and field layouts of the up/down timer
// Summary of operation
// - 16-bit up/down counter, four clock sources
// - prescale ratios 16, 256, 32768 everywhere
// - divide by 4 or 1, source dependent
// - free run wraps to opposite extreme
// - terminal count sets status bit 0
// - control bit 7: clear also reloads
// - periodic mode reloads load value
// - synced count delayed, raw count live
// - raw load write bypasses synchroniser
// - status bit 7 busy during enable crossing
// - selected bus event raises interrupt
// - selected event captures count, keeps counting
// - programmable idle level, match enable bit
// - toggle mode inverts output each timeout
// - match asserts, terminal returns to idle
// - match beats timeout on same tick
// - out-of-range match gives 0% duty
// - pwm settings apply at event or clear
// - match and timeout judged per timer tick
// - control bits 6:5 select clock source
// - fast sources forced to ratio four minimum
// - control bits 11:8 select capture event
// - capture sets bit 1, locks capture
package updown_timer_pkg;

  localparam int CNT_W = 16;
  localparam int PSC_W = 15;
  localparam int ADDR_W = 6;

  localparam logic [5:0] LD_OFF   = 6'h00;
  localparam logic [5:0] VAL_OFF  = 6'h04;
  localparam logic [5:0] CON_OFF  = 6'h08;
  localparam logic [5:0] CLRI_OFF = 6'h0C;
  localparam logic [5:0] CAP_OFF  = 6'h10;
  localparam logic [5:0] ALD_OFF  = 6'h14;
  localparam logic [5:0] AVAL_OFF = 6'h18;
  localparam logic [5:0] STA_OFF  = 6'h1C;
  localparam logic [5:0] PCON_OFF = 6'h20;
  localparam logic [5:0] PMAT_OFF = 6'h24;

  localparam logic [15:0] CON_RST   = 16'h000A;
  localparam logic [15:0] ZERO16    = 16'h0000;
  localparam logic [15:0] FULL16    = 16'hFFFF;
  localparam logic [31:0] ZERO32    = 32'h0000_0000;

  localparam int STA_TO_BIT   = 0;
  localparam int STA_CAP_BIT  = 1;
  localparam int STA_BUSY_BIT = 7;

  // enable crossing length in source clocks
  localparam logic [1:0] SYNC_TICKS = 2'h2;

  localparam logic [1:0] SRC_PCLK = 2'h0;
  localparam logic [1:0] SRC_FAST = 2'h1;

  localparam logic [1:0] PSC_LOW  = 2'h0;
  localparam logic [1:0] PSC_16   = 2'h1;
  localparam logic [1:0] PSC_256  = 2'h2;
  localparam logic [PSC_W-1:0] DIV1_M1  = 15'h0000;
  localparam logic [PSC_W-1:0] DIV4_M1  = 15'h0003;
  localparam logic [PSC_W-1:0] DIV16_M1 = 15'h000F;
  localparam logic [PSC_W-1:0] DIV256_M1 = 15'h00FF;
  localparam logic [PSC_W-1:0] DIV32K_M1 = 15'h7FFF;

  typedef struct packed {
    logic [3:0] evt_sel;
    logic       reload_on_clr;
    logic [1:0] clk_sel;
    logic       enable;
    logic       periodic_select;
    logic       count_up;
    logic [1:0] prescale;
  } timer_control_t;

  typedef struct packed {
    logic idle_level;
    logic match_en;
  } pwm_control_t;

endpackage : updown_timer_pkg

// File: test/updown_timer_with_pwm_capture_tb_top.sv
// self-checking bench for the up/down timer with capture and pwm
module updown_timer_with_pwm_capture_tb_top;
  timeunit 1ns;
  timeprecision 1ns;

  // free-run lap alone is 64k clks; everything else fits in a few thousand
  localparam int LIMIT = 90000;

  logic        clk;
  logic        rstn;
  logic [5:0]  address;
  logic        read;
  logic        write;
  logic [31:0] writedata;
  logic [31:0] readdata;
  logic        waitrequest;
  logic [2:0]  osc_q;
  logic        osc_all;
  logic [15:0] event_bus;
  logic        timer_output;
  logic        irq;
  logic [15:0] cur_ctl;
  int          div_q;
  int          cyc;
  int          err_count;
  int          checked;

  updown_timer uut (
    .clk                     (clk),
    .rstn                    (rstn),
    .ce                      (1'b1),
    .address                 (address),
    .read                    (read),
    .write                   (write),
    .writedata               (writedata),
    .byteenable              (4'h3),
    .readdata                (readdata),
    .waitrequest             (waitrequest),
    .fast_rc_oscillator      (osc_q[0]),
    .slow_rc_oscillator      (osc_q[1]),
    .slow_crystal_oscillator (osc_q[2]),
    .event_bus               (event_bus),
    .timer_output            (timer_output),
    .irq                     (irq)
  );

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // source ticks every 2, 3 and 5 clks so each source gives a distinct period
  always @(posedge clk) begin
    div_q <= (div_q == 29) ? 0 : div_q + 1;
    osc_q <= osc_all ? 3'h7 : {div_q % 5 == 0, div_q % 3 == 0, div_q % 2 == 0};
  end

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      err_count++;
      $display("Error timeout expected finish seen hang");
      test_done();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic test_done();
    $display("checked %0d errors %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : test_done

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // request held until the rising edge at which waitrequest is seen low
  task automatic bus(input logic wr_n, input logic [5:0] a, input logic [15:0] d,
                     output logic [15:0] q);
    @(posedge clk);
    address   <= a;
    read      <= ~wr_n;
    write     <= wr_n;
    writedata <= {16'h0000, d};
    do begin
      @(posedge clk);
    end while (waitrequest !== 1'b0);
    q = readdata[15:0];
    read  <= 1'b0;
    write <= 1'b0;
  endtask : bus

  task automatic wr(input logic [5:0] a, input logic [15:0] d);
    logic [15:0] q;
    bus(1'b1, a, d, q);
  endtask : wr

  task automatic rd(input logic [5:0] a, output logic [15:0] q);
    bus(1'b0, a, 16'h0000, q);
  endtask : rd

  function automatic logic [15:0] ctl(input int src, psc, up, per, evt);
    return 16'(evt * 256 + src * 32 + per * 8 + up * 4 + psc);
  endfunction : ctl

  // write control, then poll status until the domain crossing is over
  task automatic run_ctl(input logic [15:0] c, output logic seen);
    logic [15:0] s;
    int          n;
    seen = 1'b0;
    n = 0;
    wr(updown_timer_pkg::CON_OFF, c);
    do begin
      rd(updown_timer_pkg::STA_OFF, s);
      if (s[7] === 1'b1) seen = 1'b1;
      n++;
    end while (s[7] !== 1'b0 && n < 40);
  endtask : run_ctl

  // stop first: control and load may only change while disabled
  task automatic setup(input logic [15:0] c, input logic [15:0] l, output logic seen);
    run_ctl(cur_ctl & 16'hFFEF, seen);
    wr(updown_timer_pkg::CON_OFF, c);
    wr(updown_timer_pkg::LD_OFF, l);
    cur_ctl = c | 16'h0010;
    run_ctl(cur_ctl, seen);
  endtask : setup

  task automatic wait_edge(output int t);
    logic p;
    int   n;
    p = timer_output;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (timer_output === p && n < 300);
    t = cyc;
  endtask : wait_edge

  task automatic pulse(input int b);
    @(posedge clk);
    event_bus <= 16'h0001 << b;
    @(posedge clk);
    event_bus <= 16'h0000;
  endtask : pulse

  ////////////////////////////////////////////////////////////////////////////
  task automatic scen_reset();
    logic [5:0]  a [6] = '{6'h00, 6'h08, 6'h1C, 6'h20, 6'h0C, 6'h28};
    logic [15:0] e [6] = '{16'h0000, 16'h000A, 16'h0000, 16'h0000, 16'h0000, 16'h0000};
    logic [15:0] s;
    wr(updown_timer_pkg::VAL_OFF, 16'h5555);
    for (int i = 0; i < 6; i++) begin
      rd(a[i], s);
      chk("reset value", e[i], s);
    end
    rd(updown_timer_pkg::VAL_OFF, s);
    chk("read-only count", 16'h0000, s);
    wr(updown_timer_pkg::ALD_OFF, 16'h00A5);
    rd(updown_timer_pkg::ALD_OFF, s);
    chk("raw load", 16'h00A5, s);
  endtask : scen_reset

  task automatic scen_toggle();
    int          src [7] = '{0, 0, 0, 1, 2, 3, 0};
    int          psc [7] = '{0, 1, 2, 0, 0, 0, 0};
    int          up  [7] = '{0, 0, 0, 0, 0, 0, 1};
    int          per [7] = '{16, 32, 256, 16, 12, 20, 16};
    logic [15:0] ld  [7] = '{16'h0003, 16'h0001, 16'h0000, 16'h0001, 16'h0003, 16'h0003,
                             16'hFFFC};
    int          t0;
    int          t1;
    logic        seen;
    wr(updown_timer_pkg::PCON_OFF, 16'h0000);
    for (int i = 0; i < 7; i++) begin
      setup(ctl(src[i], psc[i], up[i], 1, 0), ld[i], seen);
      if (i == 5) chk("busy seen", 16'h0001, {15'h0000, seen});
      wait_edge(t0);
      wait_edge(t0);
      wait_edge(t1);
      chk("toggle period", 16'(per[i]), 16'(t1 - t0));
    end
  endtask : scen_toggle

  task automatic scen_match();
    logic [15:0] cmp [4] = '{16'h0001, 16'h0003, 16'h0004, 16'h0004};
    logic [15:0] pc  [4] = '{16'h0001, 16'h0001, 16'h0001, 16'h0003};
    logic [15:0] hi  [4] = '{16'h0020, 16'h0040, 16'h0000, 16'h0040};
    int          n;
    logic        seen;
    setup(ctl(0, 0, 0, 1, 0), 16'h0003, seen);
    for (int i = 0; i < 4; i++) begin
      wr(updown_timer_pkg::PMAT_OFF, cmp[i]);
      wr(updown_timer_pkg::PCON_OFF, pc[i]);
      wr(updown_timer_pkg::CLRI_OFF, 16'h0001);
      // let two whole periods pass before sampling four of them
      repeat (40) @(negedge clk);
      n = 0;
      repeat (64) begin
        @(negedge clk);
        if (timer_output === 1'b1) n++;
      end
      chk("pwm high clks", hi[i], 16'(n));
    end
  endtask : scen_match

  task automatic scen_irq();
    logic [15:0] s;
    logic        seen;
    int          n;
    setup(ctl(0, 0, 0, 1, 0) | 16'h0080, 16'h0100, seen);
    wr(updown_timer_pkg::CLRI_OFF, 16'h0003);
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (irq !== 1'b1 && n < 2000);
    chk("irq on timeout", 16'h0001, {15'h0000, irq});
    rd(updown_timer_pkg::STA_OFF, s);
    chk("timeout flag", 16'h0001, s);
    repeat (40) @(negedge clk);
    wr(updown_timer_pkg::CLRI_OFF, 16'h0001);
    rd(updown_timer_pkg::AVAL_OFF, s);
    chk("reload on clear", 16'h0001, {15'h0000, s >= 16'h00FE});
    chk("irq after clear", 16'h0000, {15'h0000, irq});
    rd(updown_timer_pkg::STA_OFF, s);
    chk("flag after clear", 16'h0000, s);
  endtask : scen_irq

  task automatic scen_capture();
    logic [15:0] s;
    logic        seen;
    // slowest prescale holds the count still while we probe it
    setup(ctl(0, 3, 1, 1, 3), 16'h1234, seen);
    pulse(4);
    rd(updown_timer_pkg::STA_OFF, s);
    chk("unselected event", 16'h0000, s);
    pulse(3);
    rd(updown_timer_pkg::STA_OFF, s);
    chk("capture flag", 16'h0002, s);
    chk("event irq", 16'h0001, {15'h0000, irq});
    rd(updown_timer_pkg::CAP_OFF, s);
    chk("captured count", 16'h1234, s);
    rd(updown_timer_pkg::VAL_OFF, s);
    chk("synced count", 16'h1234, s);
    rd(updown_timer_pkg::AVAL_OFF, s);
    chk("raw count", 16'h1234, s);
    wr(updown_timer_pkg::CLRI_OFF, 16'h0002);
    rd(updown_timer_pkg::STA_OFF, s);
    chk("capture cleared", 16'h0000, s);
    chk("irq released", 16'h0000, {15'h0000, irq});
  endtask : scen_capture

  task automatic scen_free();
    logic [15:0] s;
    logic        seen;
    int          n;
    // every source ticks each clk so one full 16-bit lap fits the run
    osc_all <= 1'b1;
    setup(ctl(2, 0, 1, 0, 0), 16'h0000, seen);
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (irq !== 1'b1 && n < 70000);
    chk("free-run timeout", 16'h0001, {15'h0000, irq});
    rd(updown_timer_pkg::AVAL_OFF, s);
    chk("free-run wrap", 16'h0001, {15'h0000, s < 16'h0010});
  endtask : scen_free

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    rstn      = 1'b0;
    read      = 1'b0;
    write     = 1'b0;
    address   = 6'h00;
    writedata = 32'h0000_0000;
    event_bus = 16'h0000;
    osc_q     = 3'h0;
    osc_all   = 1'b0;
    div_q     = 0;
    cyc       = 0;
    err_count = 0;
    checked   = 0;
    cur_ctl   = updown_timer_pkg::CON_RST;
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    scen_reset();
    scen_toggle();
    scen_match();
    scen_irq();
    scen_capture();
    scen_free();
    test_done();
  end

endmodule : updown_timer_with_pwm_capture_tb_top
